// file: agp_bridge_pkg.sv
`default_nettype none
package agp_bridge_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_SEC_STATUS   = 8'h1E;
	localparam logic [7:0] IDX_NP_BASE      = 8'h20;
	localparam logic [7:0] IDX_NP_LIMIT     = 8'h22;
	localparam logic [7:0] IDX_PF_BASE      = 8'h24;
	localparam logic [7:0] IDX_PF_LIMIT     = 8'h26;

	// Secondary status layout; reset value equals the hardwired pattern
	localparam logic [15:0] SEC_STATUS_RESET = 16'h02A0;
	localparam int          PARITY_BIT       = 15;
	localparam int          MASTER_ABORT_BIT = 13;
	localparam int          TARGET_ABORT_BIT = 12;
	localparam int          SIG_ABORT_BIT    = 11;
	localparam int          TIMING_HI        = 10;
	localparam int          TIMING_LO        = 9;
	localparam logic [1:0]  TIMING_MEDIUM    = 2'h1;
	localparam int          MSTR_PARITY_BIT  = 8;
	localparam int          B2B_BIT          = 7;
	localparam int          HIGH_SPEED_BIT   = 5;

	// Window register layout
	localparam int          FIELD_LSB        = 4;
	localparam int          FIELD_W          = 12;
	localparam int          LANE_W           = 8;
	localparam logic [3:0]  FIELD_PAD        = 4'h0;
	localparam logic [15:0] NP_BASE_RESET    = 16'hFFF0;
	localparam logic [15:0] NP_LIMIT_RESET   = 16'h0000;
	localparam logic [15:0] PF_BASE_RESET    = 16'hFFF0;
	localparam logic [15:0] PF_LIMIT_RESET   = 16'h0000;

	// Fill of the low address bits when comparing against a window
	localparam int          ADDR_LOW_W       = 20;
	localparam logic [19:0] BASE_LOW_FILL    = 20'h00000;
	localparam logic [19:0] LIMIT_LOW_FILL   = 20'hFFFFF;

	// Bus widths
	localparam int          WB_DATA_W        = 32;
	localparam int          REG_W            = 16;
	localparam logic [15:0] READ_PAD         = 16'h0000;

	typedef logic [FIELD_W-1:0] window_field_t;

	typedef struct packed {
		logic          parityErr;
		logic          masterAbort;
		logic          targetAbort;
		window_field_t npBase;
		window_field_t npLimit;
		window_field_t pfBase;
		window_field_t pfLimit;
		logic          fwdValid;
		logic          fwdNonPrefetch;
		logic          fwdPrefetch;
	} bridge_state_t;

	localparam bridge_state_t BRIDGE_RESET = '{
		parityErr:      1'b0,
		masterAbort:    1'b0,
		targetAbort:    1'b0,
		npBase:         NP_BASE_RESET[REG_W-1:FIELD_LSB],
		npLimit:        NP_LIMIT_RESET[REG_W-1:FIELD_LSB],
		pfBase:         PF_BASE_RESET[REG_W-1:FIELD_LSB],
		pfLimit:        PF_LIMIT_RESET[REG_W-1:FIELD_LSB],
		fwdValid:       1'b0,
		fwdNonPrefetch: 1'b0,
		fwdPrefetch:    1'b0
	};

	typedef struct packed {
		logic                 ack;
		logic [WB_DATA_W-1:0] rdData;
	} front_state_t;

	localparam front_state_t FRONT_RESET = '{ack: 1'b0, rdData: '0};

endpackage
`default_nettype wire

// file: agp_bridge_regs.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - 16-bit secondary status, resets to 02A0h
// - Bit 15 set on AGP parity error
// - Bit 13 set on received master abort
// - Bit 12 set on received target abort
// - Error flags cleared only by writing one
// - Bit 11 always reads zero
// - Bits 10:9 always read 01
// - Bit 8 always reads zero
// - Bit 7 always reads one
// - Bit 5 always reads one
// - Forward non-prefetchable when base <= address <= limit
// - Window bits 15:4 writable, 3:0 read zero
// - Base compare treats A[19:0] as zero
// - Limit compare treats A[19:0] as FFFFFh
// - Non-prefetch base FFF0h, limit 0000h at reset
// - Forward prefetchable inside its window; base FFF0h
// - Prefetch limit at 26h, resets 0000h
module agp_bridge_regs #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              wbCyc,
	input  wire logic              wbStb,
	input  wire logic              wbWe,
	input  wire logic [ADDR_W-1:0] wbAdr,
	input  wire logic [3:0]        wbSel,
	input  wire logic [31:0]       wbDatWr,
	output logic [31:0]            wbDatRd,
	output logic                   wbAck,
	input  wire logic              parityErrorEvent,
	input  wire logic              masterAbortEvent,
	input  wire logic              targetAbortEvent,
	input  wire logic              hostMemValid,
	input  wire logic [31:0]       hostMemAddr,
	output logic                   fwdValid,
	output logic                   fwdNonPrefetch,
	output logic                   fwdPrefetch,
	output logic                   fwdToAgp
);
	// Index must fit the eight-bit register index without aliasing
	generate
		if (ADDR_W < 8 || ADDR_W > 10) begin : g_bad_addr
			$error("agp_bridge_regs: ADDR_W must lie between 8 and 10");
		end
	endgenerate

	agp_bridge_pkg::bridge_state_t st_ff;
	agp_bridge_pkg::bridge_state_t nxt_st;

	cfg_port_if port ();

	logic        npHit;
	logic        pfHit;
	logic        wrAccess;
	logic        statusWrite;
	logic [15:0] statusRead;
	logic [15:0] readMux;

	// Bus front end owns the ack timing and the read data register
	wb_cfg_front #(
		.ADDR_W (ADDR_W)
	) u_front (
		.clock   (clock),
		.rst     (rst),
		.wbCyc   (wbCyc),
		.wbStb   (wbStb),
		.wbWe    (wbWe),
		.wbAdr   (wbAdr),
		.wbSel   (wbSel),
		.wbDatWr (wbDatWr),
		.wbDatRd (wbDatRd),
		.wbAck   (wbAck),
		.port    (port.front)
	);

	// Window compares run on the live register contents
	mem_window_match u_np_match (
		.baseField  (st_ff.npBase),
		.limitField (st_ff.npLimit),
		.address    (hostMemAddr),
		.hit        (npHit)
	);

	mem_window_match u_pf_match (
		.baseField  (st_ff.pfBase),
		.limitField (st_ff.pfLimit),
		.address    (hostMemAddr),
		.hit        (pfHit)
	);

	// Byte-lane merge into a window field; nibble 3:0 has no storage
	function automatic agp_bridge_pkg::window_field_t mergeField(
		input agp_bridge_pkg::window_field_t oldField,
		input logic [15:0]                   data,
		input logic [1:0]                    be
	);
		agp_bridge_pkg::window_field_t f;
		f = oldField;
		if (be[0]) begin
			f[agp_bridge_pkg::LANE_W-agp_bridge_pkg::FIELD_LSB-1:0] =
				data[agp_bridge_pkg::LANE_W-1:agp_bridge_pkg::FIELD_LSB];
		end
		if (be[1]) begin
			f[agp_bridge_pkg::FIELD_W-1:agp_bridge_pkg::LANE_W-agp_bridge_pkg::FIELD_LSB] =
				data[agp_bridge_pkg::REG_W-1:agp_bridge_pkg::LANE_W];
		end
		return f;
	endfunction

	assign wrAccess    = port.access && port.write;
	// All three error flags live in the upper byte lane
	assign statusWrite = wrAccess && port.byteEn[1] &&
		(port.index == agp_bridge_pkg::IDX_SEC_STATUS);

	// Status image: hardwired pattern plus the three sticky flags
	always_comb begin
		statusRead = agp_bridge_pkg::SEC_STATUS_RESET;
		statusRead[agp_bridge_pkg::SIG_ABORT_BIT] = 1'b0;
		statusRead[agp_bridge_pkg::TIMING_HI:agp_bridge_pkg::TIMING_LO] =
			agp_bridge_pkg::TIMING_MEDIUM;
		statusRead[agp_bridge_pkg::MSTR_PARITY_BIT] = 1'b0;
		statusRead[agp_bridge_pkg::B2B_BIT] = 1'b1;
		statusRead[agp_bridge_pkg::HIGH_SPEED_BIT] = 1'b1;
		statusRead[agp_bridge_pkg::PARITY_BIT] = st_ff.parityErr;
		statusRead[agp_bridge_pkg::MASTER_ABORT_BIT] = st_ff.masterAbort;
		statusRead[agp_bridge_pkg::TARGET_ABORT_BIT] = st_ff.targetAbort;
	end

	// Read mux; unmapped indices answer with zero rather than an error
	always_comb begin
		case (port.index)
			agp_bridge_pkg::IDX_SEC_STATUS: begin
				readMux = statusRead;
			end
			agp_bridge_pkg::IDX_NP_BASE: begin
				readMux = {st_ff.npBase, agp_bridge_pkg::FIELD_PAD};
			end
			agp_bridge_pkg::IDX_NP_LIMIT: begin
				readMux = {st_ff.npLimit, agp_bridge_pkg::FIELD_PAD};
			end
			agp_bridge_pkg::IDX_PF_BASE: begin
				readMux = {st_ff.pfBase, agp_bridge_pkg::FIELD_PAD};
			end
			agp_bridge_pkg::IDX_PF_LIMIT: begin
				readMux = {st_ff.pfLimit, agp_bridge_pkg::FIELD_PAD};
			end
			default: begin
				readMux = agp_bridge_pkg::READ_PAD;
			end
		endcase
	end

	assign port.rdData = readMux;

	// Next state: register writes, sticky flags, forwarding decode
	always_comb begin
		nxt_st = st_ff;

		// Clear first, then set, so an event in the clearing cycle survives
		if (statusWrite && port.wrData[agp_bridge_pkg::PARITY_BIT]) begin
			nxt_st.parityErr = 1'b0;
		end
		if (statusWrite && port.wrData[agp_bridge_pkg::MASTER_ABORT_BIT]) begin
			nxt_st.masterAbort = 1'b0;
		end
		if (statusWrite && port.wrData[agp_bridge_pkg::TARGET_ABORT_BIT]) begin
			nxt_st.targetAbort = 1'b0;
		end
		if (parityErrorEvent) begin
			nxt_st.parityErr = 1'b1;
		end
		if (masterAbortEvent) begin
			nxt_st.masterAbort = 1'b1;
		end
		if (targetAbortEvent) begin
			nxt_st.targetAbort = 1'b1;
		end

		// Window fields take only bits 15:4 of a write
		if (wrAccess) begin
			case (port.index)
				agp_bridge_pkg::IDX_NP_BASE: begin
					nxt_st.npBase = mergeField(st_ff.npBase, port.wrData, port.byteEn);
				end
				agp_bridge_pkg::IDX_NP_LIMIT: begin
					nxt_st.npLimit = mergeField(st_ff.npLimit, port.wrData, port.byteEn);
				end
				agp_bridge_pkg::IDX_PF_BASE: begin
					nxt_st.pfBase = mergeField(st_ff.pfBase, port.wrData, port.byteEn);
				end
				agp_bridge_pkg::IDX_PF_LIMIT: begin
					nxt_st.pfLimit = mergeField(st_ff.pfLimit, port.wrData, port.byteEn);
				end
				default: begin
					nxt_st.fwdValid = st_ff.fwdValid;
				end
			endcase
		end

		// Decode registered one cycle; a window write lands before it is used
		nxt_st.fwdValid       = hostMemValid;
		nxt_st.fwdNonPrefetch = hostMemValid && npHit;
		nxt_st.fwdPrefetch    = hostMemValid && pfHit;
	end

	// Reset leaves base above limit in both windows
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= agp_bridge_pkg::BRIDGE_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fwdValid       = st_ff.fwdValid;
	assign fwdNonPrefetch = st_ff.fwdNonPrefetch;
	assign fwdPrefetch    = st_ff.fwdPrefetch;
	// Nothing claims an address outside both windows
	assign fwdToAgp = st_ff.fwdNonPrefetch || st_ff.fwdPrefetch;
endmodule
`default_nettype wire

// file: agp_bridge_status_and_memory_windows_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Register bank bench: bus accesses, error events and window decode
module agp_bridge_status_and_memory_windows_tb_top;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [3:0]  wbSel = 4'h0;
	logic [31:0] wbDatWr = 32'h00000000;
	logic [31:0] wbDatRd;
	logic        wbAck;
	logic [2:0]  evReq = 3'h0;
	logic        parityErrorEvent, masterAbortEvent, targetAbortEvent;
	logic        hostMemValid = 1'b0;
	logic [31:0] hostMemAddr = 32'h00000000;
	logic        fwdValid, fwdNonPrefetch, fwdPrefetch, fwdToAgp;
	logic [31:0] rd;
	logic [3:0]  laneSel = 4'h3;
	int          error_cnt = 0;
	int          samples_checked = 0;

	agp_bridge_regs #(.ADDR_W(8)) i_agp_bridge_regs (.clock(clock), .rst(rst),
		.wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatWr(wbDatWr), .wbDatRd(wbDatRd), .wbAck(wbAck),
		.parityErrorEvent(parityErrorEvent), .masterAbortEvent(masterAbortEvent),
		.targetAbortEvent(targetAbortEvent), .hostMemValid(hostMemValid),
		.hostMemAddr(hostMemAddr), .fwdValid(fwdValid), .fwdNonPrefetch(fwdNonPrefetch),
		.fwdPrefetch(fwdPrefetch), .fwdToAgp(fwdToAgp));
	agp_side_model i_agp_side_model (.clock(clock), .rst(rst), .evReq(evReq),
		.parityErrorEvent(parityErrorEvent), .masterAbortEvent(masterAbortEvent),
		.targetAbortEvent(targetAbortEvent));

	// 125 MHz
	always #4 clock = ~clock;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic cycle; wait is bounded, the slave's latency is not assumed
	task xfer(input logic we, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= laneSel;
		wbDatWr <= {16'h0000, d};
		do begin
			@(posedge clock);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		check({31'h0, wbAck}, 32'h1);
		rd = wbDatRd;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask
	task rdChk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 16'h0000);
		check(rd, exp);
	endtask
	task raise(input logic [2:0] k);
		@(posedge clock);
		evReq <= k;
		@(posedge clock);
		evReq <= 3'h0;
	endtask
	// One address for one cycle, decode seen a cycle later
	task probe(input logic [31:0] a, input logic np, input logic pf);
		@(posedge clock);
		hostMemValid <= 1'b1;
		hostMemAddr <= a;
		@(posedge clock);
		hostMemValid <= 1'b0;
		#1;
		check({28'h0, fwdValid, fwdNonPrefetch, fwdPrefetch, fwdToAgp},
			{28'h0, 1'b1, np, pf, np | pf});
	endtask
	task end_of_test();
		$display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		// Reset image, and windows closed out of reset
		rdChk(8'h78, 32'h000002A0);
		rdChk(8'h80, 32'h0000FFF0);
		rdChk(8'h88, 32'h00000000);
		rdChk(8'h90, 32'h0000FFF0);
		rdChk(8'h98, 32'h00000000);
		probe(32'hFFF00000, 1'b0, 1'b0);
		probe(32'h00000000, 1'b0, 1'b0);
		// Hardwired and reserved status bits, and window bits 3:0, ignore writes
		xfer(1'b1, 8'h78, 16'h4FFF);
		rdChk(8'h78, 32'h000002A0);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, 8'h80 + 8'(i * 8), 16'hFFFF);
			rdChk(8'h80 + 8'(i * 8), 32'h0000FFF0);
		end
		// Windows programmed before any forwarding is relied on
		xfer(1'b1, 8'h80, 16'h1005);
		xfer(1'b1, 8'h88, 16'h10FF);
		xfer(1'b1, 8'h90, 16'h2000);
		xfer(1'b1, 8'h98, 16'h2000);
		rdChk(8'h80, 32'h00001000);
		// Each bound and the address just past it
		probe(32'h0FFFFFFF, 1'b0, 1'b0);
		probe(32'h10000000, 1'b1, 1'b0);
		probe(32'h10FFFFFF, 1'b1, 1'b0);
		probe(32'h11000000, 1'b0, 1'b0);
		probe(32'h1FFFFFFF, 1'b0, 1'b0);
		probe(32'h20000000, 1'b0, 1'b1);
		probe(32'h200FFFFF, 1'b0, 1'b1);
		probe(32'h20100000, 1'b0, 1'b0);
		// Each byte lane reaches only its own part of a window field
		laneSel = 4'h1;
		xfer(1'b1, 8'h80, 16'hFFE0);
		rdChk(8'h80, 32'h000010E0);
		laneSel = 4'h2;
		xfer(1'b1, 8'h80, 16'h2300);
		rdChk(8'h80, 32'h000023E0);
		laneSel = 4'h3;
		// Flags accumulate, survive zero writes, clear parity alone, then both aborts together
		raise(3'b100);
		rdChk(8'h78, 32'h000082A0);
		raise(3'b010);
		rdChk(8'h78, 32'h0000A2A0);
		raise(3'b001);
		rdChk(8'h78, 32'h0000B2A0);
		xfer(1'b1, 8'h78, 16'h4FFF);
		rdChk(8'h78, 32'h0000B2A0);
		// Flags sit in the upper lane, so a low-lane write clears nothing
		laneSel = 4'h1;
		xfer(1'b1, 8'h78, 16'hFFFF);
		laneSel = 4'h3;
		rdChk(8'h78, 32'h0000B2A0);
		xfer(1'b1, 8'h78, 16'h8000);
		rdChk(8'h78, 32'h000032A0);
		xfer(1'b1, 8'h78, 16'h3000);
		rdChk(8'h78, 32'h000002A0);
		// Event and write-one clear on the same edge: the set wins
		fork
			raise(3'b100);
			begin
				@(posedge clock);
				xfer(1'b1, 8'h78, 16'h8000);
			end
		join
		rdChk(8'h78, 32'h000082A0);
		xfer(1'b1, 8'h78, 16'h8000);
		rdChk(8'h78, 32'h000002A0);
		end_of_test();
	end
endmodule
`default_nettype wire

// file: agp_bridge_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Bus and decode checks, pins of the register bank only
module agp_bridge_sva #(
	parameter int ADDR_W = 8
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire logic              wbCyc,
	input wire logic              wbStb,
	input wire logic              wbWe,
	input wire logic [ADDR_W-1:0] wbAdr,
	input wire logic [3:0]        wbSel,
	input wire logic [31:0]       wbDatWr,
	input wire logic [31:0]       wbDatRd,
	input wire logic              wbAck,
	input wire logic              parityErrorEvent,
	input wire logic              masterAbortEvent,
	input wire logic              targetAbortEvent,
	input wire logic              hostMemValid,
	input wire logic [31:0]       hostMemAddr,
	input wire logic              fwdValid,
	input wire logic              fwdNonPrefetch,
	input wire logic              fwdPrefetch,
	input wire logic              fwdToAgp
);
	logic [7:0] idx;
	logic       rdAck;
	// Master holds the address through ack, so it still names the register
	assign idx = 8'(wbAdr >> 2);
	assign rdAck = wbAck && !wbWe;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_ackNext; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
	property p_ackOne; wbAck |=> !wbAck; endproperty
	property p_ackCause; wbAck |-> $past(wbCyc && wbStb); endproperty
	property p_rdHold; !wbAck |-> $stable(wbDatRd); endproperty
	property p_rdHigh; wbAck |-> wbDatRd[31:16] == 16'h0000; endproperty
	property p_statFixed;
		rdAck && idx == agp_bridge_pkg::IDX_SEC_STATUS |->
			!wbDatRd[14] && wbDatRd[11:0] == 12'h2A0;
	endproperty
	property p_winLow;
		rdAck && idx inside {8'h20, 8'h22, 8'h24, 8'h26} |-> wbDatRd[3:0] == 4'h0;
	endproperty
	property p_fwdGate; !hostMemValid |=> !fwdValid && !fwdToAgp; endproperty
	property p_fwdOr; fwdToAgp == (fwdNonPrefetch || fwdPrefetch); endproperty
	property p_fwdNeedsValid; fwdNonPrefetch || fwdPrefetch |-> fwdValid; endproperty
	a_ackNext: assert property (p_ackNext) else $error("no ack after request");
	a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
	a_ackCause: assert property (p_ackCause) else $error("ack without request");
	a_rdHold: assert property (p_rdHold) else $error("read data moved without ack");
	a_rdHigh: assert property (p_rdHigh) else $error("upper read half not zero");
	a_statFixed: assert property (p_statFixed) else $error("fixed status bits wrong");
	a_winLow: assert property (p_winLow) else $error("window low nibble not zero");
	a_fwdGate: assert property (p_fwdGate) else $error("forward without valid");
	a_fwdOr: assert property (p_fwdOr) else $error("forward summary wrong");
	a_fwdNeedsValid: assert property (p_fwdNeedsValid) else $error("hit without valid");
	c_statRead: cover property (rdAck && idx == agp_bridge_pkg::IDX_SEC_STATUS);
	c_npHit: cover property (fwdNonPrefetch);
	c_pfHit: cover property (fwdPrefetch);
endmodule
bind agp_bridge_regs agp_bridge_sva #(.ADDR_W(ADDR_W)) i_agp_bridge_sva (
	.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
	.wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd), .wbAck(wbAck),
	.parityErrorEvent(parityErrorEvent), .masterAbortEvent(masterAbortEvent),
	.targetAbortEvent(targetAbortEvent), .hostMemValid(hostMemValid),
	.hostMemAddr(hostMemAddr), .fwdValid(fwdValid), .fwdNonPrefetch(fwdNonPrefetch),
	.fwdPrefetch(fwdPrefetch), .fwdToAgp(fwdToAgp));
`default_nettype wire

// file: agp_side_model.sv
`timescale 1ns/10ps
`default_nettype none
// Graphics side: turns bench requests into one-cycle error events
module agp_side_model (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] evReq,
	output logic            parityErrorEvent,
	output logic            masterAbortEvent,
	output logic            targetAbortEvent
);
	// Registered so an event never moves on the edge the bench drives
	always_ff @(posedge clock) begin
		if (rst) begin
			{parityErrorEvent, masterAbortEvent, targetAbortEvent} <= 3'h0;
		end else begin
			{parityErrorEvent, masterAbortEvent, targetAbortEvent} <= evReq;
		end
	end
endmodule
`default_nettype wire

// file: cfg_port_if.sv
`timescale 1ns/10ps
`default_nettype none
// Register access strobe between the bus front end and the register bank
interface cfg_port_if;
	logic        access;
	logic        write;
	logic [7:0]  index;
	logic [15:0] wrData;
	logic [1:0]  byteEn;
	logic [15:0] rdData;

	modport front (
		output access,
		output write,
		output index,
		output wrData,
		output byteEn,
		input  rdData
	);

	modport regs (
		input  access,
		input  write,
		input  index,
		input  wrData,
		input  byteEn,
		output rdData
	);
endinterface
`default_nettype wire

// file: mem_window_match.sv
`timescale 1ns/10ps
`default_nettype none
// Inclusive compare of a 32-bit address against one 1 MB granular window
module mem_window_match (
	input  wire logic [11:0] baseField,
	input  wire logic [11:0] limitField,
	input  wire logic [31:0] address,
	output logic             hit
);
	logic [31:0] lowBound;
	logic [31:0] highBound;

	// Base expands with zeros, limit with ones, so bounds sit on 1 MB blocks
	assign lowBound  = {baseField, agp_bridge_pkg::BASE_LOW_FILL};
	assign highBound = {limitField, agp_bridge_pkg::LIMIT_LOW_FILL};
	// Base above limit gives an empty window
	assign hit = (address >= lowBound) && (address <= highBound);
endmodule
`default_nettype wire

// file: wb_cfg_front.sv
`timescale 1ns/10ps
`default_nettype none
// Classic Wishbone slave: one access per request, ack one cycle later
module wb_cfg_front #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              wbCyc,
	input  wire logic              wbStb,
	input  wire logic              wbWe,
	input  wire logic [ADDR_W-1:0] wbAdr,
	input  wire logic [3:0]        wbSel,
	input  wire logic [31:0]       wbDatWr,
	output logic [31:0]            wbDatRd,
	output logic                   wbAck,
	cfg_port_if.front              port
);
	agp_bridge_pkg::front_state_t st_ff;
	agp_bridge_pkg::front_state_t nxt_st;

	// Ack high blocks a second access from the same held request
	assign port.access = wbCyc && wbStb && !st_ff.ack;
	assign port.write  = wbWe;
	assign port.index  = 8'(wbAdr[ADDR_W-1:2]);
	assign port.wrData = wbDatWr[agp_bridge_pkg::REG_W-1:0];
	assign port.byteEn = wbSel[1:0];
	assign wbAck       = st_ff.ack;
	assign wbDatRd     = st_ff.rdData;

	// Read data captured with the access, held until the next one
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = port.access;
		if (port.access) begin
			nxt_st.rdData = {agp_bridge_pkg::READ_PAD, port.rdData};
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= agp_bridge_pkg::FRONT_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire
